// ===== rtl/sdio_defs.svh
// register offsets, field positions, reset values and timing counts
// for the stepper driver discrete i/o block; definitions only
`ifndef SDIO_DEFS_SVH
`define SDIO_DEFS_SVH
`define SDIO_CLK_HZ         40000000
`define SDIO_OFS_CTRL       6'h00
`define SDIO_OFS_STATUS     6'h04
`define SDIO_OFS_INPOS_WIN  6'h08
`define SDIO_OFS_STEP_DIV   6'h0c
`define SDIO_OFS_CMD_POS    6'h10
`define SDIO_OFS_HOME_POS   6'h14
`define SDIO_OFS_SWITCHES   6'h18
`define SDIO_OFS_OPDATA0    6'h20
`define SDIO_CTRL_PRESET    0
`define SDIO_ST_READY       0
`define SDIO_ST_MOVING      1
`define SDIO_ST_INPOS       2
`define SDIO_ST_HOMED       3
`define SDIO_ST_ALARM       4
`define SDIO_ST_LATCHED     5
`define SDIO_ST_OPNUM       8
`define SDIO_ST_STATE       12
`define SDIO_SW_NODE        0
`define SDIO_SW_MODBUS      8
`define SDIO_SW_BAUD        12
`define SDIO_SW_BAUD_BAD    16
`define SDIO_INPOS_WIN_RST  32'h00000005
`define SDIO_STEP_DIV_RST   32'h00004e20
`define SDIO_ADDR_HIGH_ADD  5'h10
`define SDIO_BAUD_NETCONV   4'h7
`define SDIO_BAUD_MAXVALID  4'h5
`define SDIO_FB_DELAY_US    100
`define SDIO_FB_TICKS ((`SDIO_CLK_HZ / 1000000) * `SDIO_FB_DELAY_US)
`define SDIO_BLINK_CYCLES   24'd10000000
`define SDIO_SAMPLE_WAIT    2'd3
`endif

// ===== rtl/sdio_pkg.sv
// types shared by the stepper driver discrete i/o block
package sdio_pkg;
  typedef enum logic [3:0] {
    SDIO_IDLE = 4'b0001,
    SDIO_POS  = 4'b0010,
    SDIO_HOME = 4'b0100,
    SDIO_JOG  = 4'b1000
  } sdio_state_t;

  // discrete host inputs, all active high (on = carrying current)
  typedef struct packed {
    logic       start;
    logic [2:0] op_select;
    logic       return_origin;
    logic       free;
    logic       stop;
    logic       fault_clear;
    logic       jog_fwd;
    logic       jog_rev;
  } sdio_in_t;

  // power-up switch settings
  typedef struct packed {
    logic [3:0] node_rotary;
    logic [1:0] dip;
    logic [3:0] baud;
  } sdio_sw_t;
endpackage : sdio_pkg

// ===== rtl/sdio_io_control.sv
// discrete i/o control of a closed-loop stepper driver with controller
// assumes: pins and switches are asynchronous to clk; alarm sources and
// sensor position come from logic on clk; avalon-mm slave, 1 wait state
`timescale 1ns/1ps
`default_nettype none
`include "sdio_defs.svh"
module sdio_io_control
  import sdio_pkg::*;
#(
  parameter int FB_TICKS = `SDIO_FB_TICKS,
  parameter int BLINK    = `SDIO_BLINK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire sdio_in_t    host_in,
  input  wire sdio_sw_t    switch_in,
  input  wire logic        alarm_event,
  input  wire logic        alarm_permanent,
  input  wire logic [31:0] sensor_position,
  output logic             home_done_output,
  output logic             in_position_output,
  output logic             pulse_accept_output,
  output logic             ready_output,
  output logic             moving_output,
  output logic             fault_output_active_off,
  output logic             feedback_phase_a,
  output logic             feedback_phase_b,
  output logic             motor_step,
  output logic             motor_dir,
  output logic             motor_current_enable,
  output logic             brake_release,
  output logic             status_indicator_red,
  output logic             status_indicator_green,
  output logic [4:0]       node_address,
  output logic             modbus_mode,
  output logic [3:0]       baud_code,
  output logic             baud_code_invalid
);
  function automatic logic [31:0] abs_diff(input logic [31:0] a,
                                           input logic [31:0] b);
    abs_diff = ($signed(a) > $signed(b)) ? a - b : b - a;
  endfunction : abs_diff
  // two-stage synchronisers for pins and switches
  sdio_in_t in_s1_reg;
  sdio_in_t in_reg;
  sdio_sw_t sw_s1_reg;
  sdio_sw_t sw_reg;
  always_ff @(posedge clk) begin
    in_s1_reg <= host_in;
    in_reg    <= in_s1_reg;
    sw_s1_reg <= switch_in;
    sw_reg    <= sw_s1_reg;
  end
  sdio_in_t in_prev_reg;
  always_ff @(posedge clk) begin
    if (rst) in_prev_reg <= '0;
    else in_prev_reg <= in_reg;
  end
  wire logic start_rise = in_reg.start & ~in_prev_reg.start;
  wire logic home_rise  = in_reg.return_origin & ~in_prev_reg.return_origin;
  wire logic clr_rise   = in_reg.fault_clear & ~in_prev_reg.fault_clear;
  // sample once
  // switches are read once the synchronisers have filled after reset
  logic [1:0] samp_cnt_reg;
  logic       sampled_reg;
  sdio_sw_t   sw_cfg_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      samp_cnt_reg <= 2'd0;
      sampled_reg  <= 1'b0;
      sw_cfg_reg   <= '0;
    end else if (!sampled_reg) begin
      samp_cnt_reg <= samp_cnt_reg + 2'd1;
      if (samp_cnt_reg == `SDIO_SAMPLE_WAIT) begin
        sampled_reg <= 1'b1;
        sw_cfg_reg  <= sw_reg;
      end
    end
  end
  assign node_address = {1'b0, sw_cfg_reg.node_rotary}
                      + (sw_cfg_reg.dip[0] ? `SDIO_ADDR_HIGH_ADD : 5'h00);
  assign modbus_mode = sw_cfg_reg.dip[1];
  assign baud_code = sw_cfg_reg.baud;
  assign baud_code_invalid = (baud_code > `SDIO_BAUD_MAXVALID)
                           & (baud_code != `SDIO_BAUD_NETCONV);
  // register file
  logic        ack_reg;
  logic [31:0] inpos_win_reg;
  logic [31:0] step_div_reg;
  logic [31:0] home_pos_reg;
  logic [31:0] opdata_reg [8];
  wire logic   bus_req  = avs_read | avs_write;
  wire logic   wr_en    = avs_write & ack_reg;
  wire logic   is_opd   = avs_address[5];
  wire logic [2:0] opd_idx = avs_address[4:2];
  wire logic   preset_wr = wr_en & (avs_address == `SDIO_OFS_CTRL)
                         & avs_writedata[`SDIO_CTRL_PRESET];
  assign avs_waitrequest = bus_req & ~ack_reg;
  always_ff @(posedge clk) begin
    if (rst) ack_reg <= 1'b0;
    else ack_reg <= bus_req & ~ack_reg;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      inpos_win_reg <= `SDIO_INPOS_WIN_RST;
      step_div_reg  <= `SDIO_STEP_DIV_RST;
      for (int i = 0; i < 8; i++) begin
        opdata_reg[i] <= '0;
      end
    end else if (wr_en) begin
      if (is_opd) begin
        opdata_reg[opd_idx] <= avs_writedata;
      end else if (avs_address == `SDIO_OFS_INPOS_WIN) begin
        inpos_win_reg <= avs_writedata;
      end else if (avs_address == `SDIO_OFS_STEP_DIV) begin
        step_div_reg <= avs_writedata;
      end
    end
  end
  // motion state
  sdio_state_t state_reg;
  sdio_state_t state_next;
  logic [31:0] cmd_pos_reg;
  logic [31:0] target_reg;
  logic [2:0]  opnum_reg;
  logic        alarm_reg;
  logic        latched_reg;
  logic        homed_reg;
  logic [31:0] div_cnt_reg;
  logic [31:0] status_word;
  logic [31:0] sw_word;
  wire logic jog_one  = in_reg.jog_fwd ^ in_reg.jog_rev;
  wire logic inhibit  = alarm_reg | in_reg.stop | in_reg.free;
  wire logic idle     = state_reg == SDIO_IDLE;
  assign ready_output = idle & ~inhibit & sampled_reg;
  wire logic go_pos   = ready_output & start_rise;
  wire logic go_home  = ready_output & home_rise & ~go_pos;
  wire logic go_jog   = ready_output & jog_one & ~go_pos & ~go_home;
  wire logic at_tgt   = cmd_pos_reg == target_reg;
  wire logic fwd      = (state_reg == SDIO_JOG) ? in_reg.jog_fwd
                      : ($signed(target_reg) > $signed(cmd_pos_reg));
  wire logic step_en  = (div_cnt_reg == 32'h0);
  wire logic do_step  = step_en & (state_reg != SDIO_IDLE) & ~inhibit
                      & ((state_reg == SDIO_JOG) ? jog_one : ~at_tgt);
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SDIO_IDLE: begin
        if (go_pos) begin
          state_next = SDIO_POS;
        end else if (go_home) begin
          state_next = SDIO_HOME;
        end else if (go_jog) begin
          state_next = SDIO_JOG;
        end
      end
      SDIO_POS, SDIO_HOME: begin
        if (at_tgt) begin
          state_next = SDIO_IDLE;
        end
      end
      SDIO_JOG: begin
        if (!jog_one) begin
          state_next = SDIO_IDLE;
        end
      end
    endcase
    // stop aborts
    // stop, free and alarm all abort; position and home moves need a fresh edge to restart, a held jog input resumes
    if (inhibit) begin
      state_next = SDIO_IDLE;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) state_reg <= SDIO_IDLE;
    else state_reg <= state_next;
  end
  // step rate divider, restarted on each move
  always_ff @(posedge clk) begin
    if (rst || idle) begin
      div_cnt_reg <= 32'h0;
    end else if (step_en) begin
      div_cnt_reg <= step_div_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg - 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_pos_reg <= '0;
      target_reg  <= '0;
      opnum_reg   <= 3'd0;
    end else begin
      if (go_pos) begin
        opnum_reg  <= in_reg.op_select;
        target_reg <= cmd_pos_reg + opdata_reg[in_reg.op_select];
      end else if (go_home) begin
        target_reg <= home_pos_reg;
      end else if (state_reg == SDIO_IDLE || state_reg == SDIO_JOG) begin
        target_reg <= cmd_pos_reg;
      end
      if (do_step) begin
        cmd_pos_reg <= fwd ? cmd_pos_reg + 32'h1 : cmd_pos_reg - 32'h1;
      end
    end
  end
  // home position and home-done
  always_ff @(posedge clk) begin
    if (rst) begin
      home_pos_reg <= '0;
      homed_reg    <= 1'b0;
    end else begin
      if (preset_wr) begin
        home_pos_reg <= cmd_pos_reg;
      end
      if (preset_wr
          || (state_reg == SDIO_HOME && at_tgt && !inhibit)) begin
        homed_reg <= 1'b1;
      end else if (go_pos || go_home || go_jog) begin
        homed_reg <= 1'b0;
      end
    end
  end
  assign home_done_output = homed_reg;
  // edge clear
  // a new alarm in the clearing cycle keeps the alarm set
  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_reg   <= 1'b0;
      latched_reg <= 1'b0;
    end else begin
      if (alarm_event) begin
        alarm_reg   <= 1'b1;
        latched_reg <= latched_reg | alarm_permanent;
      end else if (clr_rise && !latched_reg) begin
        alarm_reg <= 1'b0;
      end
    end
  end
  logic [23:0] blink_cnt_reg;
  logic        blink_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      blink_cnt_reg <= 24'h0;
      blink_reg     <= 1'b0;
    end else if (blink_cnt_reg == 24'(BLINK - 1)) begin
      blink_cnt_reg <= 24'h0;
      blink_reg     <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 24'h1;
    end
  end
  assign fault_output_active_off = ~alarm_reg;
  assign status_indicator_red    = alarm_reg & blink_reg;
  assign status_indicator_green  = ~alarm_reg;
  assign motor_current_enable = ~in_reg.free;
  assign brake_release        = in_reg.free;
  assign moving_output = ~idle & ~inhibit;
  assign pulse_accept_output = 1'b0;
  assign motor_step = do_step;
  assign motor_dir  = fwd;
  logic inpos_reg;
  always_ff @(posedge clk) begin
    if (rst) inpos_reg <= 1'b0;
    else inpos_reg <= abs_diff(sensor_position, cmd_pos_reg) <= inpos_win_reg;
  end
  assign in_position_output = inpos_reg;
  // quadrature feedback: each step ends at a phase wrap, four quarter phases apart while the direction holds, one across a reversal
  // bounded lag
  // quarter rate keeps a backlog of one step well inside the lag bound
  localparam int QTR = (FB_TICKS / 8 > 0) ? FB_TICKS / 8 : 1;
  logic signed [15:0] fb_pend_reg;
  logic [1:0]         fb_ph_reg;
  logic [15:0]        fb_tick_reg;
  wire logic fb_tick = fb_tick_reg == 16'(QTR - 1);
  wire logic fb_fwd  = fb_pend_reg > 0;
  wire logic fb_move = fb_tick & (fb_pend_reg != 0);
  wire logic [1:0] fb_ph_nx = fb_fwd ? fb_ph_reg + 2'd1 : fb_ph_reg - 2'd1;
  wire logic fb_done = fb_move & (fb_fwd ? fb_ph_reg == 2'd3
                                         : fb_ph_reg == 2'd0);
  wire logic signed [15:0] fb_add = !do_step ? 16'sd0
                                  : fwd ? 16'sd1 : -16'sd1;
  wire logic signed [15:0] fb_sub = !fb_done ? 16'sd0
                                  : fb_fwd ? 16'sd1 : -16'sd1;
  always_ff @(posedge clk) begin
    if (rst) begin
      fb_pend_reg <= 16'sd0;
      fb_ph_reg   <= 2'd0;
      fb_tick_reg <= 16'h0;
    end else begin
      fb_tick_reg <= fb_tick ? 16'h0 : fb_tick_reg + 16'h1;
      fb_pend_reg <= fb_pend_reg + fb_add - fb_sub;
      if (fb_move) begin
        fb_ph_reg <= fb_ph_nx;
      end
    end
  end
  // quadrature phases
  // forward: a leads b; b level at a's rise tells the direction
  always_ff @(posedge clk) begin
    if (rst) begin
      feedback_phase_a <= 1'b0;
      feedback_phase_b <= 1'b0;
    end else begin
      feedback_phase_a <= fb_ph_reg[0] ^ fb_ph_reg[1];
      feedback_phase_b <= fb_ph_reg[1];
    end
  end
  // readback
  always_comb begin
    status_word = '0;
    status_word[`SDIO_ST_READY]   = ready_output;
    status_word[`SDIO_ST_MOVING]  = moving_output;
    status_word[`SDIO_ST_INPOS]   = inpos_reg;
    status_word[`SDIO_ST_HOMED]   = homed_reg;
    status_word[`SDIO_ST_ALARM]   = alarm_reg;
    status_word[`SDIO_ST_LATCHED] = latched_reg;
    status_word[`SDIO_ST_OPNUM +: 3] = opnum_reg;
    status_word[`SDIO_ST_STATE +: 4] = state_reg;
    sw_word = '0;
    sw_word[`SDIO_SW_NODE +: 5] = node_address;
    sw_word[`SDIO_SW_MODBUS]    = modbus_mode;
    sw_word[`SDIO_SW_BAUD +: 4] = baud_code;
    sw_word[`SDIO_SW_BAUD_BAD]  = baud_code_invalid;
  end
  wire logic [31:0] rd_mux =
      is_opd ? opdata_reg[opd_idx]
    : (avs_address == `SDIO_OFS_STATUS)    ? status_word
    : (avs_address == `SDIO_OFS_INPOS_WIN) ? inpos_win_reg
    : (avs_address == `SDIO_OFS_STEP_DIV)  ? step_div_reg
    : (avs_address == `SDIO_OFS_CMD_POS)   ? cmd_pos_reg
    : (avs_address == `SDIO_OFS_HOME_POS)  ? home_pos_reg
    : (avs_address == `SDIO_OFS_SWITCHES)  ? sw_word
    : 32'h0;
  always_ff @(posedge clk) begin
    if (rst) avs_readdata <= '0;
    else if (avs_read && !ack_reg) avs_readdata <= rd_mux;
  end
endmodule : sdio_io_control
`default_nettype wire

// ===== test/sdio_assertions.sv
// port-level checks of the stepper driver discrete i/o block
// assumes switches stay put from reset release until sampled
`timescale 1ns/1ps
`default_nettype none
module sdio_assertions
  import sdio_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire sdio_in_t   host_in,
  input wire sdio_sw_t   switch_in,
  input wire logic       pulse_accept_output,
  input wire logic       ready_output,
  input wire logic       moving_output,
  input wire logic       fault_output_active_off,
  input wire logic       feedback_phase_a,
  input wire logic       feedback_phase_b,
  input wire logic       motor_step,
  input wire logic       motor_current_enable,
  input wire logic       brake_release,
  input wire logic [4:0] node_address,
  input wire logic       modbus_mode,
  input wire logic [3:0] baud_code,
  input wire logic       baud_code_invalid
);
  logic [2:0] age_reg;
  // cycles since reset, saturating; switches latch at the fourth
  always_ff @(posedge clk) begin
    if (rst) age_reg <= 3'h0;
    else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_pls_idle; !pulse_accept_output; endproperty
  a_pls_idle: assert property (p_pls_idle)
    else $error("pulse accept output moved");
  property p_free_cut;
    host_in.free [*4] |-> !motor_current_enable && brake_release;
  endproperty
  a_free_cut: assert property (p_free_cut)
    else $error("current still on under current cut");
  property p_stop_halt; host_in.stop [*5] |-> !moving_output; endproperty
  a_stop_halt: assert property (p_stop_halt)
    else $error("motor moving under stop");
  property p_jog_both;
    (host_in.jog_fwd && host_in.jog_rev && !host_in.start) [*6]
      |-> !moving_output;
  endproperty
  a_jog_both: assert property (p_jog_both)
    else $error("moving with both jog inputs on");
  property p_move_busy;
    (motor_step |-> moving_output) and (moving_output |-> !ready_output);
  endproperty
  a_move_busy: assert property (p_move_busy)
    else $error("ready while moving");
  property p_alm_stop; !fault_output_active_off [*3] |-> !moving_output;
  endproperty
  a_alm_stop: assert property (p_alm_stop)
    else $error("moving during alarm");
  property p_fb_gray;
    !($changed(feedback_phase_a) && $changed(feedback_phase_b));
  endproperty
  a_fb_gray: assert property (p_fb_gray)
    else $error("both feedback phases toggled at once");
  property p_sw_hold;
    age_reg > 3'h5 |->
      $stable({node_address, modbus_mode, baud_code, baud_code_invalid});
  endproperty
  a_sw_hold: assert property (p_sw_hold)
    else $error("switch outputs changed after sampling");
  property p_sw_map;
    age_reg == 3'h6 |-> modbus_mode == switch_in.dip[1] &&
      node_address == {switch_in.dip[0], switch_in.node_rotary};
  endproperty
  a_sw_map: assert property (p_sw_map)
    else $error("node address or protocol wrong");
  property p_baud_map;
    age_reg == 3'h6 |-> baud_code == switch_in.baud && baud_code_invalid ==
      (switch_in.baud == 4'h6 || switch_in.baud > 4'h7);
  endproperty
  a_baud_map: assert property (p_baud_map)
    else $error("baud code or flag wrong");
  c_move: cover property ($fell(ready_output));
  c_alarm: cover property ($fell(fault_output_active_off));
  c_fb: cover property ($rose(feedback_phase_a));
endmodule : sdio_assertions
`default_nettype wire

// ===== test/sdio_host_model.sv
// host controller model: drives start, select and return-home pins
// assumes the bench supplies all other pin levels through man
`timescale 1ns/1ps
`default_nettype none
module sdio_host_model
  import sdio_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic       home,
  input  wire logic [2:0] op,
  input  wire sdio_in_t   man,
  input  wire logic       ready_output,
  output var  sdio_in_t   host_in,
  output logic            busy
);
  logic [1:0] ph_reg;
  logic       req_reg;
  logic       home_reg;
  logic [2:0] op_reg;
  assign busy = ph_reg != 2'h0;
  always_comb begin
    host_in = man;
    host_in.op_select = op_reg;
    host_in.start = req_reg & ~home_reg;
    host_in.return_origin = req_reg & home_reg;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_reg <= 2'h0;
      req_reg <= 1'b0;
      home_reg <= 1'b0;
      op_reg <= 3'h0;
    end else begin
      case (ph_reg)
        2'h0: begin
          op_reg <= op;
          home_reg <= home;
          if (go) ph_reg <= 2'h1;
        end
        2'h1: if (ready_output) begin
          req_reg <= 1'b1;
          ph_reg <= 2'h2;
        end
        // held until taken, else the edge is lost
        default: if (!ready_output) begin
          req_reg <= 1'b0;
          ph_reg <= 2'h0;
        end
      endcase
    end
  end
endmodule : sdio_host_model
`default_nettype wire

// ===== test/sdio_io_control_tb.sv
// self-checking bench of the stepper driver discrete i/o block
// assumes the host model owns start, select and return-home pins
`timescale 1ns/1ps
`default_nettype none
module sdio_io_control_tb
  import sdio_pkg::*;
  ;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest, go, home;
  logic        alarm_event, alarm_permanent, busy, modbus_mode;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, sensor_position, q, rnd;
  logic [2:0]  op;
  logic [10:0] es;
  logic [4:0]  node_address;
  logic [3:0]  baud_code;
  logic        home_done_output, in_position_output, pulse_accept_output;
  logic        ready_output, moving_output, fault_output_active_off;
  logic        feedback_phase_a, feedback_phase_b, motor_step, motor_dir;
  logic        motor_current_enable, brake_release, status_indicator_red;
  logic        status_indicator_green, baud_code_invalid;
  sdio_in_t    man, host_in;
  sdio_sw_t    switch_in, sw;
  int          n_mismatch, total_checks, fbn, stn, xp, hp;
  int          d [8];
  sdio_io_control #(.FB_TICKS(16), .BLINK(8)) sdio_io_control_i (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .host_in, .switch_in, .alarm_event,
    .alarm_permanent, .sensor_position, .home_done_output,
    .in_position_output, .pulse_accept_output, .ready_output,
    .moving_output, .fault_output_active_off, .feedback_phase_a,
    .feedback_phase_b, .motor_step, .motor_dir, .motor_current_enable,
    .brake_release, .status_indicator_red, .status_indicator_green,
    .node_address, .modbus_mode, .baud_code, .baud_code_invalid);
  sdio_host_model sdio_host_model_i (.clk, .rst, .go, .home, .op, .man,
    .ready_output, .host_in, .busy);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (motor_step === 1'b1) stn <= stn + (motor_dir ? 1 : -1);
  // direction from b level at a rise
  always @(posedge feedback_phase_a) fbn <= fbn + (feedback_phase_b ? -1 : 1);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [10:0] exp_sw(input sdio_sw_t s);
    logic bad;
    bad = (s.baud == 4'h6) || (s.baud > 4'h7);
    return {s.dip[0], s.node_rotary, s.dip[1], s.baud, bad};
  endfunction : exp_sw
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic upto(input int n, ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < n) begin
      @(posedge clk);
      k++;
    end
    if (s !== v) begin
      n_mismatch++;
      $display("MISMATCH %0t wait ran out", $time);
      results();
    end
  endtask : upto
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] dt);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= dt;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge clk);
    upto(50, avs_waitrequest, 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [5:0] a, input logic [31:0] m, e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rd
  task automatic move(input logic h, input logic [2:0] o, input int n);
    go <= 1'b1;
    home <= h;
    op <= o;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    upto(40, busy, 1'b0);
    op <= ~o;
    @(posedge clk);
    if (n > 0) upto(n, ready_output, 1'b1);
  endtask : move
  task automatic ip(input int o, input logic e);
    sensor_position <= xp + o;
    repeat (3) @(posedge clk);
    chk(in_position_output, e);
  endtask : ip
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    $display("MISMATCH %0t run too long", $time);
    results();
  end
  initial begin
    {avs_read, avs_write, alarm_event, alarm_permanent, go, home} = '0;
    {avs_address, avs_writedata, sensor_position, op} = '0;
    {man, switch_in, n_mismatch, total_checks, fbn, stn, xp} = '0;
    rst = 1'b1;
    rnd = 32'hc945;
    for (int i = 0; i < 16; i++) begin
      rnd = xs(rnd);
      sw = {rnd[5:0], i[3:0]};
      if (sw.dip == 2'h2 && sw.node_rotary == 4'h0) sw.node_rotary = 4'h1;
      switch_in <= sw;
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      chk({node_address, modbus_mode, baud_code, baud_code_invalid},
          exp_sw(sw));
    end
    switch_in <= ~sw;
    repeat (8) @(posedge clk);
    chk({node_address, modbus_mode, baud_code, baud_code_invalid}, exp_sw(sw));
    es = exp_sw(sw);
    rd(6'h18, 32'h1f11f,
       {es[0], es[4:1], 3'h0, es[5], 3'h0, es[10:6]});
    rd(6'h08, '1, 32'h5);
    rd(6'h0c, '1, 32'h4e20);
    rd(6'h1c, '1, 32'h0);
    bus(1'b1, 6'h0c, 32'h7);
    for (int k = 0; k < 8; k++) begin
      rnd = xs(rnd);
      d[k] = $signed(rnd[3:0]);
      bus(1'b1, 6'(32 + 4 * k), d[k]);
    end
    for (int k = 0; k < 8; k++) begin
      move(1'b0, k[2:0], 400);
      xp += d[k];
      rd(6'h04, 32'h700, 32'(k) << 8);
      rd(6'h10, '1, xp);
      chk(stn, xp);
    end
    repeat (100) @(posedge clk);
    chk(fbn, xp);
    ip(0, 1'b1);
    ip(6, 1'b0);
    ip(-5, 1'b1);
    ip(-6, 1'b0);
    bus(1'b1, 6'h00, 32'h1);
    hp = xp;
    repeat (2) @(posedge clk);
    chk(home_done_output, 1'b1);
    bus(1'b1, 6'h24, 32'h9);
    move(1'b0, 3'h1, 400);
    chk(home_done_output, 1'b0);
    move(1'b1, 3'h0, 400);
    chk({home_done_output, ready_output}, 2'b11);
    rd(6'h10, '1, hp);
    bus(1'b1, 6'h20, 32'h7d0);
    move(1'b0, 3'h0, 0);
    repeat (20) @(posedge clk);
    man.stop <= 1'b1;
    upto(10, moving_output, 1'b0);
    repeat (4) @(posedge clk);
    man.stop <= 1'b0;
    repeat (30) @(posedge clk);
    chk({moving_output, ready_output}, 2'b01);
    man.free <= 1'b1;
    repeat (5) @(posedge clk);
    chk({motor_current_enable, brake_release}, 2'b01);
    man.free <= 1'b0;
    man.jog_fwd <= 1'b1;
    repeat (12) @(posedge clk);
    chk({moving_output, motor_dir}, 2'b11);
    man.jog_rev <= 1'b1;
    repeat (8) @(posedge clk);
    chk(moving_output, 1'b0);
    man.jog_fwd <= 1'b0;
    repeat (12) @(posedge clk);
    chk({moving_output, motor_dir}, 2'b10);
    man.jog_rev <= 1'b0;
    man.fault_clear <= 1'b1;
    repeat (8) @(posedge clk);
    alarm_event <= 1'b1;
    @(posedge clk);
    alarm_event <= 1'b0;
    upto(30, status_indicator_red, 1'b1);
    chk({fault_output_active_off, status_indicator_green}, 2'b00);
    for (int p = 0; p < 2; p++) begin
      man.fault_clear <= 1'b0;
      repeat (4) @(posedge clk);
      man.fault_clear <= 1'b1;
      repeat (5) @(posedge clk);
      chk(fault_output_active_off, p == 0);
      {alarm_event, alarm_permanent} <= 2'b11;
      @(posedge clk);
      {alarm_event, alarm_permanent} <= 2'b00;
    end
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({fault_output_active_off, status_indicator_green}, 2'b11);
    results();
  end
endmodule : sdio_io_control_tb
bind sdio_io_control sdio_assertions sdio_assertions_i (.clk, .rst,
  .host_in, .switch_in, .pulse_accept_output, .ready_output,
  .moving_output, .fault_output_active_off, .feedback_phase_a,
  .feedback_phase_b, .motor_step, .motor_current_enable, .brake_release,
  .node_address, .modbus_mode, .baud_code, .baud_code_invalid);
`default_nettype wire
